// ==== gateway_consts.svh ====
`ifndef GATEWAY_CONSTS_SVH
`define GATEWAY_CONSTS_SVH
// ----------------------------------------------------------------
// indicator colour codes {red, green}
// ----------------------------------------------------------------
`define COLOUR_OFF 2'h0
`define COLOUR_GREEN 2'h1
`define COLOUR_RED 2'h2
`define COLOUR_AMBER 2'h3
// ----------------------------------------------------------------
// port counts and timing
// ----------------------------------------------------------------
`define CARD_COUNT 18
`define SHELF_ADDR_W 8
`define CLK_MHZ 125
`define BLINK_HALF_MS 250
`define BLINK_HALF_CYC (`BLINK_HALF_MS * 1000 * `CLK_MHZ)
`endif

// ==== gateway_pkg.sv ====
package gateway_pkg;
  typedef enum logic [1:0] {
    link_down_t_dummy, link_train, link_low, link_high
  } link_state_t;
  typedef enum logic [2:0] {
    boot_reset, boot_prog, boot_done, boot_capture, boot_cap_ok,
    boot_cap_fail, boot_run
  } boot_state_t;
endpackage

// ==== card_switch.sv ====
`timescale 1ns/100ps
`include "gateway_consts.svh"
module card_switch #(
  parameter int CARDS = `CARD_COUNT,
  parameter int AW = `SHELF_ADDR_W
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // ring ingress
  input wire logic ring_valid,
  input wire logic [7:0] ring_data,
  input wire logic [AW-1:0] ring_shelf,
  input wire logic [4:0] ring_card,
  input wire logic [AW-1:0] local_shelf,
  // forwarding decision from network processor
  input wire logic fwd_enable,
  // per-card egress
  output logic [CARDS-1:0] card_valid,
  output logic [7:0] card_data [CARDS],
  // ring pass-through
  output logic pass_valid,
  output logic [7:0] pass_data
);
  // ----------------------------------------------------------------
  // address match and per-card steering
  // ----------------------------------------------------------------
  wire logic local_hit = ring_valid && fwd_enable &&
    (ring_shelf == local_shelf);
  wire logic pass_hit = ring_valid && !(ring_shelf == local_shelf);

  // one register per card, separate paths
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      card_valid <= '0;
      pass_valid <= 1'b0;
      pass_data <= 8'h00;
      for (int i = 0; i < CARDS; i++) card_data[i] <= 8'h00;
    end else begin
      pass_valid <= pass_hit;
      pass_data <= ring_data;
      for (int i = 0; i < CARDS; i++) begin
        card_valid[i] <= local_hit && (int'(ring_card) == i);
        if (local_hit && (int'(ring_card) == i)) card_data[i] <= ring_data;
      end
    end
  end

  a_local_only: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    $countones(card_valid) <= 1)
    else $error("more than one card port active");
  // only the addressed card sees the beat, one edge after it is taken
  a_card_steer: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    card_valid == ($past(local_hit) ?
      (CARDS'(1) << $past(ring_card)) : CARDS'(0)))
    else $error("card port not steered to addressed card");
endmodule

// ==== shelf_gateway.sv ====
// Notes on behaviour
// - bridge 125 Mbps bus and 2.5 Gbps ring
// - local-shelf ring data goes straight to card
// - every card owns a dedicated switched port
// - one path per card confines faults
// - processor decides, core switches
// - four tri-colour front-panel indicators
// - processor indicator red, amber, green during boot
// - boot indicator dark before load, location dark or amber on warm start
// - capture: location amber, boot shows outcome
// - running: location green on address match
// - operational link: steady low, blinking high
// - negotiating or proving link shows amber
// - non-operational link shows red
`timescale 1ns/100ps
`include "gateway_consts.svh"
module shelf_gateway #(
  parameter int CARDS = `CARD_COUNT,
  parameter int AW = `SHELF_ADDR_W,
  parameter int BLINK_HALF = `BLINK_HALF_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // warm start flag held outside the reset domain
  input wire logic warm_flag_in,
  output logic warm_flag_out,
  // boot sequencing from pins
  input wire logic logic_programming,
  input wire logic logic_loaded,
  input wire logic capture_timer_run,
  input wire logic capture_ok,
  input wire logic capture_fail,
  input wire logic code_running,
  // shelf address from maintenance_subsystem and read-back
  input wire logic [AW-1:0] assigned_addr,
  input wire logic [AW-1:0] readback_addr,
  // ring link state from pins
  input wire logic link_up,
  input wire logic link_training,
  input wire logic link_high_rate,
  // ring ingress from same clock
  input wire logic ring_valid,
  input wire logic [7:0] ring_data,
  input wire logic [AW-1:0] ring_shelf,
  input wire logic [4:0] ring_card,
  input wire logic fwd_enable,
  // card ports
  output logic [CARDS-1:0] card_valid,
  output logic [7:0] card_data [CARDS],
  output logic pass_valid,
  output logic [7:0] pass_data,
  // indicators {red, green}
  output logic [1:0] rate_led,
  output logic [1:0] boot_led,
  output logic [1:0] shelf_led,
  output logic [1:0] processor_state_indicator
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  localparam int NS = 9;
  wire logic [NS-1:0] raw = {warm_flag_in, logic_programming, logic_loaded,
    capture_timer_run, capture_ok, capture_fail, code_running,
    link_training, link_high_rate};
  logic [NS-1:0] sync_a;
  logic [NS-1:0] sync_b;
  logic link_a;
  logic link_b;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync_a <= '0;
      sync_b <= '0;
      link_a <= 1'b0;
      link_b <= 1'b0;
    end else begin
      sync_a <= raw;
      sync_b <= sync_a;
      link_a <= link_up;
      link_b <= link_a;
    end
  end
  wire logic s_warm = sync_b[8];
  wire logic s_prog = sync_b[7];
  wire logic s_loaded = sync_b[6];
  wire logic s_timer = sync_b[5];
  wire logic s_ok = sync_b[4];
  wire logic s_fail = sync_b[3];
  wire logic s_run = sync_b[2];
  wire logic s_train = sync_b[1];
  wire logic s_high = sync_b[0];

  // ----------------------------------------------------------------
  // warm start flag: set once loaded, survives reset outside
  // ----------------------------------------------------------------
  logic warm;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) warm <= 1'b0;
    else warm <= s_warm | s_loaded;
  end
  assign warm_flag_out = warm;

  // ----------------------------------------------------------------
  // boot sequencer
  // ----------------------------------------------------------------
  gateway_pkg::boot_state_t state;
  gateway_pkg::boot_state_t next_state;
  always_comb begin
    next_state = state;
    unique case (state)
      gateway_pkg::boot_reset: if (s_prog) next_state = gateway_pkg::boot_prog;
      gateway_pkg::boot_prog:
        if (s_loaded) next_state = gateway_pkg::boot_done;
      gateway_pkg::boot_done:
        if (s_timer) next_state = gateway_pkg::boot_capture;
      gateway_pkg::boot_capture: begin
        if (s_ok) next_state = gateway_pkg::boot_cap_ok;
        else if (s_fail) next_state = gateway_pkg::boot_cap_fail;
      end
      gateway_pkg::boot_cap_ok, gateway_pkg::boot_cap_fail:
        if (s_run) next_state = gateway_pkg::boot_run;
      gateway_pkg::boot_run: next_state = gateway_pkg::boot_run;
      default: next_state = gateway_pkg::boot_reset;
    endcase
  end
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) state <= gateway_pkg::boot_reset;
    else state <= next_state;
  end

  // ----------------------------------------------------------------
  // address compare while running
  // ----------------------------------------------------------------
  wire logic addr_match = (assigned_addr == readback_addr);

  // ----------------------------------------------------------------
  // blink timer for high-rate indication
  // ----------------------------------------------------------------
  logic [31:0] blink_cnt;
  logic blink;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      blink_cnt <= 32'h00000000;
      blink <= 1'b0;
    end else if (blink_cnt >= 32'(BLINK_HALF - 1)) begin
      blink_cnt <= 32'h00000000;
      blink <= ~blink;
    end else begin
      blink_cnt <= blink_cnt + 32'h00000001;
    end
  end

  // ----------------------------------------------------------------
  // indicator decoding
  // ----------------------------------------------------------------
  wire logic pre_load = (state == gateway_pkg::boot_reset) ||
    (state == gateway_pkg::boot_prog);
  wire logic [1:0] next_processor_state_indicator = (state == gateway_pkg::boot_reset) ?
    `COLOUR_RED : (state == gateway_pkg::boot_prog) ? `COLOUR_AMBER :
    `COLOUR_GREEN;
  wire logic [1:0] next_boot =
    pre_load ? `COLOUR_OFF :
    (state == gateway_pkg::boot_cap_ok || state == gateway_pkg::boot_run) ?
      `COLOUR_GREEN :
    (state == gateway_pkg::boot_cap_fail) ? `COLOUR_RED : `COLOUR_AMBER;
  wire logic [1:0] next_shelf =
    pre_load ? (warm ? `COLOUR_AMBER : `COLOUR_OFF) :
    (state == gateway_pkg::boot_run) ?
      (addr_match ? `COLOUR_GREEN : `COLOUR_RED) : `COLOUR_AMBER;
  wire logic [1:0] next_rate =
    pre_load ? `COLOUR_OFF :
    !link_b ? `COLOUR_RED :
    s_train ? `COLOUR_AMBER :
    (s_high && !blink) ? `COLOUR_OFF : `COLOUR_GREEN;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      processor_state_indicator <= `COLOUR_RED;
      boot_led <= `COLOUR_OFF;
      shelf_led <= `COLOUR_OFF;
      rate_led <= `COLOUR_OFF;
    end else begin
      processor_state_indicator <= next_processor_state_indicator;
      boot_led <= next_boot;
      shelf_led <= next_shelf;
      rate_led <= next_rate;
    end
  end

  // ----------------------------------------------------------------
  // card switch; processor gates forwarding, core switches
  // ----------------------------------------------------------------
  card_switch #(.CARDS(CARDS), .AW(AW)) u_switch (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .ring_valid(ring_valid),
    .ring_data(ring_data),
    .ring_shelf(ring_shelf),
    .ring_card(ring_card),
    .local_shelf(readback_addr),
    .fwd_enable(fwd_enable && (state == gateway_pkg::boot_run)),
    .card_valid(card_valid),
    .card_data(card_data),
    .pass_valid(pass_valid),
    .pass_data(pass_data)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_processor_state_indicator_reset: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    $past(state) == gateway_pkg::boot_reset |->
    processor_state_indicator == `COLOUR_RED)
    else $error("processor indicator not red in reset");
  a_dark_preload: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    $past(pre_load) |-> boot_led == `COLOUR_OFF)
    else $error("boot indicator lit before load");
  a_cap_fail: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    $past(state) == gateway_pkg::boot_cap_fail |->
    boot_led == `COLOUR_RED)
    else $error("failed capture not red");
  a_match_green: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    $past(state) == gateway_pkg::boot_run && $past(addr_match) |->
    shelf_led == `COLOUR_GREEN)
    else $error("address match not green");
  a_link_red: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    !$past(pre_load) && !$past(link_b) |-> rate_led == `COLOUR_RED)
    else $error("down link not red");
  a_link_amber: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    !$past(pre_load) && $past(link_b) && $past(s_train) |->
    rate_led == `COLOUR_AMBER)
    else $error("training link not amber");
  a_low_steady: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    !$past(pre_load) && $past(link_b) && !$past(s_train) &&
    !$past(s_high) |-> rate_led == `COLOUR_GREEN)
    else $error("low rate not steady green");
  a_warm_amber: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    $past(pre_load) && $past(warm) |-> shelf_led == `COLOUR_AMBER)
    else $error("warm start location not amber");
  c_run: cover property (@(posedge ref_clk) state == gateway_pkg::boot_run);
  c_fail: cover property (@(posedge ref_clk)
    state == gateway_pkg::boot_cap_fail);
  c_fwd: cover property (@(posedge ref_clk) card_valid != '0);
endmodule

// ==== ring_neighbour.sv ====
`timescale 1ns/100ps
module ring_neighbour (
  // clock
  input wire logic ref_clk,
  // ring beat toward the gateway
  output logic ring_valid,
  output logic [7:0] ring_data,
  output logic [7:0] ring_shelf,
  output logic [4:0] ring_card
);
  // idle ring before the first beat
  initial begin
    ring_valid = 1'b0;
    ring_data = 8'h00;
    ring_shelf = 8'h00;
    ring_card = 5'h00;
  end
  // one beat held across the taking edge, then idle shows inverse
  task automatic send(input logic [7:0] shelf, input logic [4:0] card,
                      input logic [7:0] data);
    @(negedge ref_clk);
    ring_valid = 1'b1;
    ring_shelf = shelf;
    ring_card = card;
    ring_data = data;
    @(negedge ref_clk);
    ring_valid = 1'b0;
    ring_shelf = ~shelf;
    ring_card = ~card;
    ring_data = ~data;
  endtask
endmodule

// ==== test_shelf_gateway.sv ====
`timescale 1ns/100ps
`include "gateway_consts.svh"
module test_shelf_gateway;
  localparam logic [7:0] HOME = 8'h2A;
  logic ref_clk, sys_rst, warm_flag_in, warm_flag_out, fwd_enable;
  logic logic_programming, logic_loaded, capture_timer_run, capture_ok;
  logic capture_fail, code_running, link_up, link_training, link_high_rate;
  logic [7:0] assigned_addr, readback_addr, ring_data, ring_shelf, pass_data;
  logic [4:0] ring_card;
  logic ring_valid, pass_valid;
  logic [17:0] card_valid;
  logic [7:0] card_data [18];
  logic [1:0] rate_led, boot_led, shelf_led, processor_state_indicator;
  int fails, num_checks;
  // ----------------------------------------------------------------
  // design and ring neighbour
  // ----------------------------------------------------------------
  shelf_gateway #(.CARDS(18), .AW(8), .BLINK_HALF(4)) i_shelf_gateway (
    .ref_clk, .sys_rst, .warm_flag_in, .warm_flag_out, .logic_programming,
    .logic_loaded, .capture_timer_run, .capture_ok, .capture_fail,
    .code_running, .assigned_addr, .readback_addr, .link_up, .link_training,
    .link_high_rate, .ring_valid, .ring_data, .ring_shelf, .ring_card,
    .fwd_enable, .card_valid, .card_data, .pass_valid, .pass_data,
    .rate_led, .boot_led, .shelf_led, .processor_state_indicator);
  ring_neighbour i_ring_neighbour (.ref_clk, .ring_valid, .ring_data,
    .ring_shelf, .ring_card);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic leds(input logic [1:0] b, s, p);
    chk(boot_led, b);
    chk(shelf_led, s);
    chk(processor_state_indicator, p);
  endtask
  task automatic settle;
    repeat (6) @(negedge ref_clk);
  endtask
  task automatic rate_count(input int n, output int g, output int o);
    g = 0;
    o = 0;
    repeat (n) begin
      @(negedge ref_clk);
      if (rate_led === `COLOUR_GREEN) g++;
      if (rate_led === `COLOUR_OFF) o++;
    end
  endtask
  task automatic test_done;
    if (fails == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_boot(input logic warm, input logic ok);
    logic [1:0] s;
    s = warm ? `COLOUR_AMBER : `COLOUR_OFF;
    @(negedge ref_clk);
    {logic_programming, logic_loaded, capture_timer_run, capture_ok,
     capture_fail, code_running, link_up, link_training} = '0;
    {link_high_rate, fwd_enable} = '0;
    warm_flag_in = warm;
    assigned_addr = HOME;
    sys_rst = 1'b1;
    repeat (20) @(negedge ref_clk);
    sys_rst = 1'b0;
    settle();
    leds(`COLOUR_OFF, s, `COLOUR_RED);
    chk(rate_led, `COLOUR_OFF);
    logic_programming = 1'b1;
    settle();
    leds(`COLOUR_OFF, s, `COLOUR_AMBER);
    logic_loaded = 1'b1;
    settle();
    leds(`COLOUR_AMBER, `COLOUR_AMBER, `COLOUR_GREEN);
    chk(warm_flag_out, 1'b1);
    chk(rate_led, `COLOUR_RED);
    capture_timer_run = 1'b1;
    settle();
    leds(`COLOUR_AMBER, `COLOUR_AMBER, `COLOUR_GREEN);
    capture_ok = ok;
    capture_fail = !ok;
    settle();
    s = ok ? `COLOUR_GREEN : `COLOUR_RED;
    leds(s, `COLOUR_AMBER, `COLOUR_GREEN);
    fwd_enable = 1'b1;
    i_ring_neighbour.send(HOME, 5'h01, 8'h11);
    chk(card_valid, 18'h0);
    fwd_enable = 1'b0;
    code_running = 1'b1;
    settle();
    chk(shelf_led, `COLOUR_GREEN);
    assigned_addr = HOME ^ 8'h01;
    settle();
    chk(shelf_led, `COLOUR_RED);
    assigned_addr = HOME;
    settle();
  endtask
  task automatic t_forward;
    fwd_enable = 1'b1;
    foreach (card_data[n]) begin
      i_ring_neighbour.send(HOME, 5'(n), 8'hA0 + 8'(n));
      chk(card_valid, 18'h1 << n);
      chk(card_data[n], 8'hA0 + 8'(n));
      chk(pass_valid, 1'b0);
    end
    i_ring_neighbour.send(HOME ^ 8'hFF, 5'h03, 8'h5C);
    chk(pass_valid, 1'b1);
    chk(pass_data, 8'h5C);
    chk(card_valid, 18'h0);
    i_ring_neighbour.send(HOME, 5'h12, 8'h77);
    chk(card_valid, 18'h0);
    @(negedge ref_clk);
    fwd_enable = 1'b0;
    i_ring_neighbour.send(HOME, 5'h02, 8'h33);
    chk(card_valid, 18'h0);
  endtask
  task automatic t_link;
    int g, o;
    link_up = 1'b1;
    link_training = 1'b1;
    settle();
    chk(rate_led, `COLOUR_AMBER);
    link_training = 1'b0;
    settle();
    rate_count(12, g, o);
    chk(g, 12);
    link_high_rate = 1'b1;
    settle();
    rate_count(16, g, o);
    chk(g, 8);
    chk(o, 8);
    link_up = 1'b0;
    settle();
    chk(rate_led, `COLOUR_RED);
  endtask
  // ----------------------------------------------------------------
  // clock, main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    sys_rst = 1'b1;
    warm_flag_in = 1'b0;
    readback_addr = HOME;
    assigned_addr = HOME;
    {logic_programming, logic_loaded, capture_timer_run, capture_ok,
     capture_fail, code_running, link_up, link_training} = '0;
    {link_high_rate, fwd_enable} = '0;
    t_boot(1'b0, 1'b1);
    t_forward();
    t_link();
    t_boot(1'b1, 1'b0);
    test_done();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    test_done();
  end
endmodule
